// ---- pma_host_model.sv ----
// Host side of the alarm line: pulls it low for a requested span.
// Assumes no pull resistor, so an undriven line changes every cycle.
`timescale 1ns/10ps
`default_nettype none
module pma_host_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       clr_go,
  input  wire logic [7:0] clr_len,
  input  wire logic       link_out,
  output logic            link_in
);
  logic [7:0] low_q;
  logic       float_q;
  // Low span held for the full count asked
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_q <= 8'h00;
      float_q <= 1'b0;
    end else begin
      low_q <= clr_go ? clr_len : low_q - {7'h00, low_q != 8'h00};
      float_q <= ~float_q;
    end
  end
  // Host pull beats the device drive
  assign link_in = (low_q != 8'h00) ? 1'b0 : (link_out ? 1'b1 : float_q);
endmodule : pma_host_model
`default_nettype wire

// ---- pma_motion_alarm.sv ----
// Motion alarm interface: converter source select, motion detection on the
// band-pass path, alarm line driver with host clear and blind interval.
// Assumes config arrives already deserialised from the serial input, and
// the alarm line inputs are synchronous to clock.
//
// Behaviour
// R01: Motion is judged only from the band-pass path.
// R02: Detection runs only while the mode field selects motion alarm.
// R03: A met motion criterion drives the alarm line high.
// R04: The alarm stays high until the host clears it; the code also drops it whenever the mode leaves motion alarm.
// R05: The host clears by holding the line low for at least 160 us.
// R06: After a clear, detection is suppressed for the blind interval.
// R07: Config is unknown until the host writes a full word.
// R08: Config is written only through the serial configuration input.
// R09: The line serves as motion interrupt or as data readout by mode; the code drives it from alarm only and just flags readout modes on stream_mode.
// R10: The converter source is chosen among the elements and temperature.
// R11: Samples are 14 bit, valid between 511 and full scale minus 511.
// R12: Sample period is at least 2.0 ms, at most 12.5 ms in interrupt readout.
// R13: All sequencing runs from the internal oscillator time base; the clear counter low_q counts clock cycles instead.
// R14: Mode encodes forced 0, interrupt 1, alarm 2, 3 reserved.
// R15: Blind time is 0.5 s to 8 s in 0.5 s steps, starting at the clear.
// R16: Motion is met when pulses over threshold in the window reach the count.
// R17: The line input is measured low by a counter before a clear is taken.
`timescale 1ns/10ps
`default_nettype none
module pma_motion_alarm
  import pma_pkg::*;
#(
  parameter int unsigned CLEAR_CYC     = CLEAR_MIN_CYC,
  parameter int unsigned OSC_DIVIDE    = OSC_DIV,
  parameter int unsigned BLIND_TICKS   = BLIND_STEP_TICKS,
  parameter int unsigned WINDOW_TICKS  = WINDOW_STEP_TICKS,
  parameter int unsigned SMPL_TICKS    = SAMPLE_MIN_TICKS
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  input  wire logic                 cfg_load,
  input  wire logic [CFG_W-1:0]     cfg_word,
  input  wire pma_pkg::pma_samp_t   samp,
  input  wire logic                 link_in,
  output logic                      link_out,
  output logic                      link_oe,
  output logic                      sample_strobe,
  output logic [ADC_W-1:0]          sel_data,
  output logic                      out_of_range,
  output logic                      cfg_valid,
  output logic                      alarm,
  output logic                      blind_active,
  output logic                      stream_mode
);

  // ---------------------------------------------------------------
  // Configuration capture
  // ---------------------------------------------------------------
  pma_cfg_t cfg_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_q     <= '0;
      cfg_valid <= 1'b0;
    end else if (clk_en && cfg_load) begin // [R08]
      cfg_q.threshold      <= cfg_word[THR_LSB +: 8];
      cfg_q.blind          <= cfg_word[BLIND_LSB +: 4];
      cfg_q.pulses         <= cfg_word[PCNT_LSB +: 2];
      cfg_q.window         <= cfg_word[WIN_LSB +: 2];
      cfg_q.mode           <= pma_mode_t'(cfg_word[MODE_LSB +: 2]);
      cfg_q.source         <= pma_src_t'(cfg_word[SRC_LSB +: 2]);
      cfg_q.no_sign_change <= cfg_word[CMODE_BIT];
      cfg_valid            <= 1'b1; // [R07]
    end
  end

  // No mode is active on an unwritten config; sample pacing and the source mux still run
  logic alarm_mode;
  assign alarm_mode  = cfg_valid && (cfg_q.mode == PMA_MODE_ALARM); // [R02] [R14]
  assign stream_mode = cfg_valid && (cfg_q.mode == PMA_MODE_FORCED
                                  || cfg_q.mode == PMA_MODE_IRQ); // [R09] [R14]

  // ---------------------------------------------------------------
  // Oscillator time base and sample pacing
  // ---------------------------------------------------------------
  logic osc_tick;

  pma_tick_div #(
    .DIV (OSC_DIVIDE)
  ) u_osc (
    .clock  (clock),
    .rstn   (rstn),
    .clk_en (clk_en),
    .tick   (osc_tick)
  );

  logic [7:0] smpl_q;
  logic       take;
  assign take = osc_tick && (smpl_q == 8'(SMPL_TICKS - 1)) && samp.valid; // [R12] [R13]

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      smpl_q        <= '0;
      sample_strobe <= 1'b0;
    end else if (clk_en) begin
      sample_strobe <= take;
      if (osc_tick) begin
        smpl_q <= (smpl_q == 8'(SMPL_TICKS - 1)) ? 8'h00 : smpl_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Source mux and range check
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_data     <= '0;
      out_of_range <= 1'b0;
    end else if (clk_en && take) begin
      unique case (cfg_q.source) // [R10]
        PMA_SRC_BPF:  sel_data <= samp.band_pass_path;
        PMA_SRC_LPF:  sel_data <= samp.low_pass_path;
        PMA_SRC_TEMP: sel_data <= samp.temp;
        default:      sel_data <= '0;
      endcase
      out_of_range <= (samp.low_pass_path < ADC_LO) || (samp.low_pass_path > ADC_HI); // [R11]
    end
  end

  // ---------------------------------------------------------------
  // Pulse detection on band-pass data
  // ---------------------------------------------------------------
  logic signed [ADC_W-1:0] bpf_s;
  logic [ADC_W-1:0]        mag;
  logic                    over;
  logic                    last_sign_q;
  logic                    pulse;

  assign bpf_s = signed'(samp.band_pass_path); // [R01]
  assign mag   = bpf_s[ADC_W-1] ? (~samp.band_pass_path + 14'h0001) : samp.band_pass_path;
  assign over  = mag > {6'h00, cfg_q.threshold};
  // Sign-change mode rejects repeated same-polarity lobes
  assign pulse = take && over && (cfg_q.no_sign_change || (bpf_s[ADC_W-1] != last_sign_q));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last_sign_q <= 1'b0;
    end else if (clk_en && take && over) begin
      last_sign_q <= bpf_s[ADC_W-1];
    end
  end

  // ---------------------------------------------------------------
  // Host clear detection on the line
  // ---------------------------------------------------------------
  logic [$clog2(CLEAR_CYC+1)-1:0] low_q;
  logic                           clear_evt;

  // Only a held-low long enough counts; short glitches are ignored
  assign clear_evt = clk_en && alarm && !link_in
                  && (low_q == ($clog2(CLEAR_CYC+1))'(CLEAR_CYC - 1)); // [R05] [R17]

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_q <= '0;
    end else if (clk_en) begin
      if (link_in || !alarm) begin
        low_q <= '0;
      end else if (low_q != ($clog2(CLEAR_CYC+1))'(CLEAR_CYC)) begin
        low_q <= low_q + 1'b1; // [R17]
      end
    end
  end

  // ---------------------------------------------------------------
  // Blind interval
  // ---------------------------------------------------------------
  logic [4:0]  blind_steps_q;
  logic [19:0] blind_tk_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      blind_steps_q <= '0;
      blind_tk_q    <= '0;
    end else if (clk_en) begin
      if (clear_evt) begin
        blind_steps_q <= {1'b0, cfg_q.blind} + 5'h01; // [R06] [R15]
        blind_tk_q    <= '0;
      end else if (blind_steps_q != 5'h00 && osc_tick) begin // [R13]
        if (blind_tk_q == 20'(BLIND_TICKS - 1)) begin
          blind_tk_q    <= '0;
          blind_steps_q <= blind_steps_q - 5'h01;
        end else begin
          blind_tk_q <= blind_tk_q + 20'h0_0001;
        end
      end
    end
  end
  assign blind_active = (blind_steps_q != 5'h00);

  // ---------------------------------------------------------------
  // Moving window of pulse ages
  // ---------------------------------------------------------------
  localparam int unsigned SLOTS = 4;
  logic [21:0] age_q [SLOTS];
  logic [SLOTS-1:0] live_q;
  logic [21:0] win_len;
  logic [2:0]  live_cnt;
  logic        armed;
  logic        motion;

  assign win_len = 22'(({20'h0_0000, cfg_q.window} + 22'h00_0001) * WINDOW_TICKS);
  assign armed   = alarm_mode && !blind_active && !alarm; // [R02] [R06]

  always_comb begin
    live_cnt = 3'h0;
    for (int i = 0; i < SLOTS; i++) begin
      live_cnt = live_cnt + {2'b00, live_q[i]};
    end
  end
  // Count reaches 1 + field with the newest pulse included
  assign motion = armed && pulse
               && ((live_cnt + 3'h1) >= ({1'b0, cfg_q.pulses} + 3'h1)); // [R16]

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      live_q <= '0;
      for (int i = 0; i < SLOTS; i++) age_q[i] <= '0;
    end else if (clk_en) begin
      if (!armed) begin
        live_q <= '0;
      end else begin
        for (int i = 0; i < SLOTS; i++) begin
          if (live_q[i] && osc_tick) begin
            if (age_q[i] >= win_len - 22'h00_0001) live_q[i] <= 1'b0;
            else age_q[i] <= age_q[i] + 22'h00_0001;
          end
        end
        // Oldest slot is overwritten when all are full
        if (pulse) begin
          for (int i = SLOTS-1; i > 0; i--) begin
            age_q[i]  <= age_q[i-1];
            live_q[i] <= live_q[i-1];
          end
          age_q[0]  <= '0;
          live_q[0] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Alarm latch and line drive
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alarm <= 1'b0;
    end else if (clk_en) begin
      if (motion) begin
        alarm <= 1'b1; // [R03]
      end else if (clear_evt || !alarm_mode) begin
        alarm <= 1'b0; // [R04]
      end
    end
  end

  // Device drives high only; host owns the low level when clearing
  assign link_out = alarm; // [R03] [R09]
  assign link_oe  = alarm && link_in;

endmodule : pma_motion_alarm
`default_nettype wire

// ---- pma_motion_alarm_asserts.sv ----
// Checker for the motion alarm block, watching its ports only.
// Assumes one clock domain and clk_en held high during checks.
`timescale 1ns/10ps
`default_nettype none
module pma_motion_alarm_chk
  import pma_pkg::*;
#(
  parameter int unsigned CLEAR_CYC  = 8,
  parameter int unsigned OSC_DIVIDE = 4,
  parameter int unsigned SMPL_TICKS = 2
) (
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic               clk_en,
  input wire logic               cfg_load,
  input wire logic [CFG_W-1:0]   cfg_word,
  input wire pma_pkg::pma_samp_t samp,
  input wire logic               link_in,
  input wire logic               link_out,
  input wire logic               link_oe,
  input wire logic               sample_strobe,
  input wire logic [ADC_W-1:0]   sel_data,
  input wire logic               out_of_range,
  input wire logic               cfg_valid,
  input wire logic               alarm,
  input wire logic               blind_active,
  input wire logic               stream_mode
);
  logic [15:0] lo_q;
  logic [15:0] gap_q;
  // ----------------
  // Helper counters
  // ----------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) lo_q <= 16'h0000;
    else if (clk_en) lo_q <= link_in ? 16'h0000 : lo_q + 16'h0001;
  end
  // Saturates so the first strobe after reset never fires
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) gap_q <= 16'hffff;
    else if (clk_en) gap_q <= sample_strobe ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hffff};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_cfg; cfg_load && clk_en |=> cfg_valid; endproperty
  property p_drive; (link_out == alarm) && (link_oe == (alarm && link_in)); endproperty
  // A mode change reaches the latch two cycles after its load
  property p_hold; alarm && link_in && !cfg_load && !$past(cfg_load) |=> alarm; endproperty
  property p_clear;
    alarm && !link_in && lo_q == CLEAR_CYC - 1 && !cfg_load |=> !alarm ##1 blind_active;
  endproperty
  property p_fell;
    $fell(alarm) && !$past(cfg_load) && !$past(cfg_load, 2) |-> $past(lo_q) == CLEAR_CYC - 1;
  endproperty
  property p_blind; $rose(alarm) |-> !$past(blind_active); endproperty
  property p_take; $rose(alarm) |-> sample_strobe && !$past(stream_mode); endproperty
  property p_gap; sample_strobe |-> gap_q >= SMPL_TICKS * OSC_DIVIDE - 1; endproperty
  property p_oor;
    sample_strobe && $past(samp.valid) |->
      out_of_range == ($past(samp.low_pass_path) < ADC_LO || $past(samp.low_pass_path) > ADC_HI);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config not marked valid");
  a_drive: assert property (p_drive) else $error("line drive wrong");
  a_hold: assert property (p_hold) else $error("alarm dropped alone");
  a_clear: assert property (p_clear) else $error("clear not taken");
  a_fell: assert property (p_fell) else $error("clear too early");
  a_blind: assert property (p_blind) else $error("alarm in blind time");
  a_take: assert property (p_take) else $error("alarm off sample");
  a_gap: assert property (p_gap) else $error("sample period short");
  a_oor: assert property (p_oor) else $error("range flag wrong");
  c_set: cover property ($rose(alarm));
  c_clr: cover property ($fell(alarm));
  c_blind: cover property ($fell(blind_active));
endmodule : pma_motion_alarm_chk
`default_nettype wire

// ---- pma_pkg.sv ----
// Package for the motion alarm interface: config layout, modes, timing.
// Assumes a single 250 MHz clock domain.
package pma_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CLEAR_MIN_US     = 160;
  localparam int unsigned CLEAR_MIN_CYC    = CLEAR_MIN_US * CLK_MHZ;
  localparam int unsigned BLIND_STEP_MS    = 500;
  localparam int unsigned WINDOW_STEP_MS   = 2000;
  localparam int unsigned SAMPLE_MIN_US    = 2000;
  localparam int unsigned SAMPLE_MAX_US    = 12500;
  localparam int unsigned OSC_NOM_KHZ      = 32;
  // Oscillator tick divider at the nominal rate
  localparam int unsigned OSC_DIV          = (CLK_MHZ * 1000) / OSC_NOM_KHZ;
  // Ticks of the internal oscillator per interval step
  localparam int unsigned BLIND_STEP_TICKS = BLIND_STEP_MS * OSC_NOM_KHZ;
  localparam int unsigned WINDOW_STEP_TICKS = WINDOW_STEP_MS * OSC_NOM_KHZ;
  localparam int unsigned SAMPLE_MIN_TICKS = (SAMPLE_MIN_US * OSC_NOM_KHZ + 999) / 1000;
  localparam int unsigned SAMPLE_MAX_TICKS = (SAMPLE_MAX_US * OSC_NOM_KHZ) / 1000;

  // ---------------------------------------------------------------
  // Converter data
  // ---------------------------------------------------------------
  localparam int unsigned ADC_W      = 14;
  localparam logic [13:0] ADC_LO     = 14'h01ff;
  localparam logic [13:0] ADC_HI     = 14'h3e01;

  // ---------------------------------------------------------------
  // Configuration word fields
  // ---------------------------------------------------------------
  localparam int unsigned CFG_W       = 25;
  localparam int unsigned THR_LSB     = 17;
  localparam int unsigned BLIND_LSB   = 13;
  localparam int unsigned PCNT_LSB    = 11;
  localparam int unsigned WIN_LSB     = 9;
  localparam int unsigned MODE_LSB    = 7;
  localparam int unsigned SRC_LSB     = 5;
  localparam int unsigned CMODE_BIT   = 0;

  typedef enum logic [1:0] {
    PMA_MODE_FORCED = 2'h0,
    PMA_MODE_IRQ    = 2'h1,
    PMA_MODE_ALARM  = 2'h2,
    PMA_MODE_RSVD   = 2'h3
  } pma_mode_t;

  typedef enum logic [1:0] {
    PMA_SRC_BPF  = 2'h0,
    PMA_SRC_LPF  = 2'h1,
    PMA_SRC_RSVD = 2'h2,
    PMA_SRC_TEMP = 2'h3
  } pma_src_t;

  typedef struct packed {
    logic [7:0] threshold;
    logic [3:0] blind;
    logic [1:0] pulses;
    logic [1:0] window;
    pma_mode_t  mode;
    pma_src_t   source;
    logic       no_sign_change;
  } pma_cfg_t;

  typedef struct packed {
    logic              valid;
    logic [ADC_W-1:0]  band_pass_path;
    logic [ADC_W-1:0]  low_pass_path;
    logic [ADC_W-1:0]  temp;
  } pma_samp_t;

endpackage : pma_pkg

// ---- pma_tick_div.sv ----
// Free-running divider producing a one-cycle tick.
// Models the on-chip oscillator time base from the system clock.
`timescale 1ns/10ps
`default_nettype none
module pma_tick_div #(
  parameter int unsigned DIV = 7812
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic clk_en,
  output logic      tick
);
  import pma_pkg::*;

  logic [$clog2(DIV)-1:0] cnt_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (clk_en) begin
      tick <= (cnt_q == ($clog2(DIV))'(DIV - 1));
      if (cnt_q == ($clog2(DIV))'(DIV - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : pma_tick_div
`default_nettype wire

// ---- tb.sv ----
// Bench for the motion alarm block with a host model on the alarm line.
// Assumes shortened timing parameters: tick 4 cycles, take every 8.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pma_pkg::*;
  localparam int unsigned CLR = 8;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic cfg_load = 1'b0;
  logic [CFG_W-1:0] cfg_word = '0;
  pma_samp_t samp = '0;
  logic clr_go = 1'b0;
  logic [7:0] clr_len = 8'h00;
  logic link_in, link_out, link_oe, sample_strobe, out_of_range;
  logic cfg_valid, alarm, blind_active, stream_mode;
  logic [ADC_W-1:0] sel_data;
  int fail_count = 0;
  int n_compared = 0;
  always #2 clock = ~clock;
  pma_motion_alarm #(.CLEAR_CYC(CLR), .OSC_DIVIDE(4), .BLIND_TICKS(3), .WINDOW_TICKS(10),
    .SMPL_TICKS(2)) i_pma_motion_alarm (.clock, .rstn, .clk_en, .cfg_load, .cfg_word,
    .samp, .link_in, .link_out, .link_oe, .sample_strobe, .sel_data, .out_of_range,
    .cfg_valid, .alarm, .blind_active, .stream_mode);
  pma_host_model i_pma_host_model (.clock, .rstn, .clr_go, .clr_len, .link_out, .link_in);
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic do_reset();
    @(posedge clock) rstn <= 1'b0;
    tick(16);
    chk("reset outs", {alarm, link_oe, cfg_valid, sample_strobe, blind_active}, 0);
    @(posedge clock) rstn <= 1'b1;
  endtask : do_reset
  // Count mode fixed at no sign change; reserved fields as required
  task automatic load(logic [7:0] thr, logic [3:0] bl, logic [1:0] pc, logic [1:0] md,
                      logic [1:0] src);
    @(posedge clock);
    cfg_load <= 1'b1;
    cfg_word <= {thr, bl, pc, 2'h0, md, src, 2'h2, 2'h0, 1'b1};
    @(posedge clock);
    cfg_load <= 1'b0;
    #1;
    chk("cfg_valid", cfg_valid, 1);
  endtask : load
  task automatic wstb();
    int i;
    i = 0;
    do begin
      tick(1);
      i++;
    end while (sample_strobe !== 1'b1 && i < 40);
    chk("strobe", sample_strobe, 1);
  endtask : wstb
  task automatic pull(int n);
    @(posedge clock);
    clr_len <= 8'(n);
    clr_go <= 1'b1;
    @(posedge clock);
    clr_go <= 1'b0;
    tick(2);
    chk("line released", link_oe, 0);
  endtask : pull
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      load(8'hff, 4'h0, 2'h0, m[1:0], 2'h0);
      chk("stream_mode", stream_mode, m < 2);
    end
    $display("modes done");
  endtask : t_modes
  task automatic t_src();
    logic [13:0] ex [4] = '{14'h0012, 14'h01fe, 14'h0000, 14'h2345};
    logic [13:0] lv [3] = '{14'h01ff, 14'h3e00, 14'h3e02};
    @(posedge clock) samp <= {1'b1, 14'h0012, 14'h01fe, 14'h2345};
    for (int s = 0; s < 4; s++) begin
      load(8'hff, 4'h0, 2'h0, 2'h0, s[1:0]);
      wstb();
      chk("sel_data", sel_data, ex[s]);
      chk("out_of_range", out_of_range, 1);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clock) samp.low_pass_path <= lv[k];
      wstb();
      wstb();
      chk("range edge", out_of_range, k == 2);
    end
    $display("sources done");
  endtask : t_src
  task automatic t_alarm();
    int hi;
    int bad;
    hi = 0;
    bad = 0;
    do_reset();
    @(posedge clock) samp <= {1'b1, 14'h0000, 14'h3000, 14'h3fff};
    load(8'h10, 4'h1, 2'h0, 2'h2, 2'h1);
    wstb();
    wstb();
    chk("alarm low pass", alarm, 0);
    load(8'h10, 4'h1, 2'h0, 2'h1, 2'h0);
    @(posedge clock) samp.band_pass_path <= 14'h0100;
    wstb();
    wstb();
    chk("alarm irq mode", alarm, 0);
    load(8'h10, 4'h1, 2'h0, 2'h2, 2'h0);
    wstb();
    chk("alarm set", {alarm, link_out, link_oe}, 3'b111);
    tick(100);
    chk("alarm held", alarm, 1);
    pull(CLR - 1);
    tick(CLR);
    chk("short clear", alarm, 1);
    pull(CLR);
    for (int i = 0; i < 80 && (hi == 0 || blind_active === 1'b1); i++) begin
      hi += int'(blind_active === 1'b1);
      bad += int'(blind_active === 1'b1 && alarm !== 1'b0);
      tick(1);
    end
    chk("blind length", hi >= 20 && hi <= 25, 1);
    chk("alarm in blind", bad, 0);
    wstb();
    chk("alarm after blind", alarm, 1);
    $display("alarm done");
  endtask : t_alarm
  task automatic t_pulses();
    do_reset();
    @(posedge clock) samp <= {1'b1, 14'h3f00, 14'h2000, 14'h2000};
    load(8'h10, 4'h0, 2'h1, 2'h2, 2'h0);
    wstb();
    chk("one pulse", alarm, 0);
    wstb();
    chk("two pulses", alarm, 1);
    $display("pulses done");
  endtask : t_pulses
  // Pending alarm, line pulled low while frozen: no clear may be counted
  task automatic t_freeze();
    wstb();
    tick(1);
    @(posedge clock) clk_en <= 1'b0;
    pull(CLR + 4);
    tick(CLR + 4);
    chk("frozen alarm", {alarm, blind_active}, 2'b10);
    @(posedge clock) clk_en <= 1'b1;
    tick(2);
    chk("thawed alarm", alarm, 1);
    $display("freeze done");
  endtask : t_freeze
  // Count mode 0: a repeated polarity is not counted, a flipped one is
  task automatic t_sign();
    do_reset();
    @(posedge clock) samp <= {1'b1, 14'h3f00, 14'h2000, 14'h2000};
    @(posedge clock) cfg_load <= 1'b1;
    cfg_word <= {8'h10, 4'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 3'h0};
    @(posedge clock) cfg_load <= 1'b0;
    wstb();
    wstb();
    chk("same sign", alarm, 0);
    @(posedge clock) samp.band_pass_path <= 14'h0100;
    wstb();
    chk("sign change", alarm, 1);
    $display("sign done");
  endtask : t_sign
  initial begin
    do_reset();
    t_modes();
    t_src();
    t_alarm();
    t_pulses();
    t_freeze();
    t_sign();
    close_out();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule : tb
bind pma_motion_alarm pma_motion_alarm_chk #(.CLEAR_CYC(CLEAR_CYC), .OSC_DIVIDE(OSC_DIVIDE),
  .SMPL_TICKS(SMPL_TICKS)) i_pma_motion_alarm_chk (.clock, .rstn, .clk_en, .cfg_load,
  .cfg_word, .samp, .link_in, .link_out, .link_oe, .sample_strobe, .sel_data, .out_of_range,
  .cfg_valid, .alarm, .blind_active, .stream_mode);
`default_nettype wire
